// >>> hdl/dkg_top.sv
/*
 * dkg_top.sv: direct-key gpio input unit with apb register slave.
 * assumes: pins 0..23 are gpio/key lines, 24..25 key-only lines;
 * pin inputs are asynchronous; pad logic resolves out/oe/pulls.
 */
// Local design decision: the APB interface to the registers.
// Behaviour
// (R1) key select bit 1 makes pin a direct key over all else; resets to 1
// (R2) software clears key select before assigning another pin function
// (R3) each key event enters an eight-entry byte fifo read via event code, unless the fifo is full
// (R4) empty fifo reads 0x3f when all released, 0x1f when any pressed
// (R5) event bit 5 is 0 for press, 1 for release; bits 7:6 zero
// (R6) five-bit code is pin index plus one; 0x1f marks empty
// (R7) key-selected pins are always de-bounced
// (R8) de-bounce time is 128 clocks times five-bit count; count resets 6
// (R9) sync bit 5 de-bounces plain gpio inputs; resets 0
// (R10) lost flag sets on overflow, stays until event clear write or software reset
// (R11) raw event flag high while fifo holds events, clears when empty
// (R12) masked bit follows raw while mask bit 0, reads 0 when 1
// (R13) enabled host irq output goes low while any masked bit is 1
// (R14) clear bit 0 write of 1 flushes fifo and both raw flags
// (R15) mask bit 1 gates lost, bit 0 gates event; both reset 0
// (R16) gpio irq watches input pins only, level or edge, maskable
// (R17) pending gpio irq cleared by software reset or irq clear write
// (R18) trigger pulses must last more than one clock
// (R19) push-pull or pseudo open drain output, per-pin pull up or down
// (R20) after any reset all gpio pins are inputs
// (R21) software reset returns pull configuration to default
// (R22) active unmasked gpio irq raises wake and irq outputs
// (R23) open drain polarity 1 drives high on 1; polarity 0 drives low on 0
// (R24) each event code read returns and removes the oldest event
// (R25) events beyond eight are dropped, only the lost flag records them
`timescale 1ns/1ps
`default_nettype none
`include "dkg_cfg.svh"

module dkg_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dkg_pkg::dkg_keys_t pin_in,
	output dkg_pkg::dkg_gpio_t pin_out,
	output dkg_pkg::dkg_gpio_t pin_oe,
	output dkg_pkg::dkg_gpio_t pull_up,
	output dkg_pkg::dkg_gpio_t pull_dn,
	output logic host_irq_n,
	output logic gpio_irq,
	output logic wake
);
	import dkg_pkg::*;

	// ============================================================
	// apb slave
	logic [31:0] prdata_q, rd_data;
	logic pready_q, pslverr_q, hit, acc, pop_pend_q;
	logic [9:0] idx;
	assign idx = paddr[11:2];
	assign acc = psel && penable && pready_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	logic srst_q;
	logic [5:0] db_q;
	dkg_keys_t ksel_q, sync1_q, sync2_q, deb, clean, rep_q;
	dkg_gpio_t dir_q, data_q, ode_q, odm_q, pu_q, pd_q;
	dkg_gpio_t is_q, ibe_q, iev_q, ie_q, gris_q, gprev_q;
	logic [1:0] msk_q, raw, mis;
	logic irqen_q, lost_q;
	logic [3:0] cnt_q;
	logic [2:0] wp_q, rp_q;
	dkg_byte_t fifo_q [8];
	dkg_byte_t head;

	function automatic logic wr(input logic [9:0] ix);
		wr = acc && pwrite && idx == ix;
	endfunction

	always_comb begin
		hit = 1'b1;
		rd_data = 32'h0;
		unique case (idx)
			`DKG_IX_EVT: rd_data = {24'h0, head};
			`DKG_IX_DB: rd_data = {26'h0, db_q};
			`DKG_IX_SEL0: rd_data = {24'h0, ksel_q[7:0]};
			`DKG_IX_SEL1: rd_data = {24'h0, ksel_q[15:8]};
			`DKG_IX_SEL2: rd_data = {24'h0, ksel_q[23:16]};
			`DKG_IX_SEL3: rd_data = {30'h0, ksel_q[25:24]};
			`DKG_IX_RIS: rd_data = {30'h0, raw};
			`DKG_IX_MIS: rd_data = {30'h0, mis};
			`DKG_IX_CLR, `DKG_IX_GIC: rd_data = 32'h0;
			`DKG_IX_MSK: rd_data = {30'h0, msk_q};
			`DKG_IX_DIR: rd_data = {8'h0, dir_q};
			`DKG_IX_DATA: rd_data = {8'h0, data_q};
			`DKG_IX_ODE: rd_data = {8'h0, ode_q};
			`DKG_IX_ODM: rd_data = {8'h0, odm_q};
			`DKG_IX_PU: rd_data = {8'h0, pu_q};
			`DKG_IX_PD: rd_data = {8'h0, pd_q};
			`DKG_IX_IS: rd_data = {8'h0, is_q};
			`DKG_IX_IBE: rd_data = {8'h0, ibe_q};
			`DKG_IX_IEV: rd_data = {8'h0, iev_q};
			`DKG_IX_IE: rd_data = {8'h0, ie_q};
			`DKG_IX_GRIS: rd_data = {8'h0, gris_q};
			`DKG_IX_CTRL: rd_data = {31'h0, irqen_q};
			`DKG_IX_PIN: rd_data = {6'h0, clean};
			default: hit = 1'b0;
		endcase
	end

	// answer comes one cycle after the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
			pop_pend_q <= 1'b0;
		end else if (psel && penable && !pready_q) begin
			pready_q <= 1'b1;
			pslverr_q <= !hit;
			prdata_q <= pwrite ? 32'h0 : rd_data;
			pop_pend_q <= !pwrite && idx == `DKG_IX_EVT && cnt_q != 4'h0; // R24
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			pop_pend_q <= 1'b0;
		end
	end

	// ============================================================
	// control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			srst_q <= 1'b0;
		end else begin
			srst_q <= wr(`DKG_IX_CTRL) && pwdata[`DKG_CTRL_SRST_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ksel_q <= `DKG_SEL_RESET; // R1
			db_q <= `DKG_DB_RESET; // R8 R9
			msk_q <= 2'h0; // R15
			irqen_q <= 1'b0;
		end else if (srst_q) begin
			ksel_q <= `DKG_SEL_RESET;
			db_q <= `DKG_DB_RESET;
			msk_q <= 2'h0;
			irqen_q <= 1'b0;
		end else begin
			if (wr(`DKG_IX_SEL0)) ksel_q[7:0] <= pwdata[7:0];
			if (wr(`DKG_IX_SEL1)) ksel_q[15:8] <= pwdata[7:0];
			if (wr(`DKG_IX_SEL2)) ksel_q[23:16] <= pwdata[7:0];
			if (wr(`DKG_IX_SEL3)) ksel_q[25:24] <= pwdata[1:0];
			if (wr(`DKG_IX_DB)) db_q <= pwdata[5:0];
			if (wr(`DKG_IX_MSK)) msk_q <= pwdata[1:0]; // R15
			if (wr(`DKG_IX_CTRL)) irqen_q <= pwdata[`DKG_CTRL_IRQEN_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{dir_q, data_q, ode_q, odm_q} <= '0; // R20
			{pu_q, pd_q, is_q, ibe_q, iev_q, ie_q} <= '0;
		end else if (srst_q) begin
			{dir_q, data_q, ode_q, odm_q} <= '0; // R20
			{pu_q, pd_q, is_q, ibe_q, iev_q, ie_q} <= '0; // R21
		end else begin
			if (wr(`DKG_IX_DIR)) dir_q <= pwdata[23:0];
			if (wr(`DKG_IX_DATA)) data_q <= pwdata[23:0];
			if (wr(`DKG_IX_ODE)) ode_q <= pwdata[23:0];
			if (wr(`DKG_IX_ODM)) odm_q <= pwdata[23:0];
			if (wr(`DKG_IX_PU)) pu_q <= pwdata[23:0]; // R19
			if (wr(`DKG_IX_PD)) pd_q <= pwdata[23:0]; // R19
			if (wr(`DKG_IX_IS)) is_q <= pwdata[23:0];
			if (wr(`DKG_IX_IBE)) ibe_q <= pwdata[23:0];
			if (wr(`DKG_IX_IEV)) iev_q <= pwdata[23:0];
			if (wr(`DKG_IX_IE)) ie_q <= pwdata[23:0];
		end
	end

	// ============================================================
	// input synchroniser and de-bounce
	logic [6:0] div_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '1;
			sync2_q <= '1;
			div_q <= 7'h00;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			div_q <= 7'(div_q + 7'h01);
		end
	end

	dkg_debounce u_deb (
		.pclk(pclk),
		.presetn(presetn),
		.srst(srst_q),
		.step(div_q == `DKG_DB_DIV_LAST),
		.count(db_q[4:0]), // R8
		.raw(sync2_q),
		.clean(deb)
	);

	// key lines always filtered, gpio lines only with sync set
	assign clean = (ksel_q | {26{db_q[`DKG_DB_SYNC_BIT]}}) & deb // R7 R9
		| ~(ksel_q | {26{db_q[`DKG_DB_SYNC_BIT]}}) & sync2_q;

	// ============================================================
	// key event detection, one event per cycle, lowest pin first
	logic ev_valid;
	logic [4:0] ev_pin;
	always_comb begin
		ev_valid = 1'b0;
		ev_pin = 5'h00;
		for (int i = 25; i >= 0; i--) begin
			if (ksel_q[i] && clean[i] != rep_q[i]) begin
				ev_valid = 1'b1;
				ev_pin = 5'(i);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rep_q <= '1;
		end else if (srst_q) begin
			rep_q <= '1;
		end else begin
			rep_q <= rep_q | ~ksel_q;
			if (ev_valid) rep_q[ev_pin] <= clean[ev_pin];
		end
	end

	// ============================================================
	// event fifo
	logic push, pop, flush, full;
	assign flush = srst_q || (wr(`DKG_IX_CLR) && pwdata[`DKG_CLR_EVT_BIT]); // R14
	assign full = cnt_q == `DKG_FIFO_DEPTH;
	assign push = ev_valid && !full; // R25
	assign pop = acc && pop_pend_q; // R24
	assign head = cnt_q != 4'h0 ? fifo_q[rp_q] // R24
		: ((ksel_q & ~rep_q) != '0 ? `DKG_CODE_HELD : `DKG_CODE_IDLE); // R4

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_q <= 3'h0;
			rp_q <= 3'h0;
			cnt_q <= 4'h0;
		end else if (flush) begin
			// an event in the flush cycle survives as the only entry unless the fifo was full
			wp_q <= push ? 3'h1 : 3'h0; // R14
			rp_q <= 3'h0;
			cnt_q <= push ? 4'h1 : 4'h0;
		end else begin
			if (push) wp_q <= 3'(wp_q + 3'h1); // R3
			if (pop) rp_q <= 3'(rp_q + 3'h1);
			cnt_q <= 4'(cnt_q + {3'h0, push} - {3'h0, pop});
		end
	end

	always_ff @(posedge pclk) begin
		if (push) fifo_q[flush ? 3'h0 : wp_q] <= {2'b00, clean[ev_pin], // R5
			5'(ev_pin + 5'h01)}; // R6
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lost_q <= 1'b0;
		end else begin
			// overflow set wins over a clear in the same cycle
			lost_q <= (ev_valid && full) || (lost_q && !flush); // R10 R25
		end
	end

	assign raw = {lost_q, cnt_q != 4'h0}; // R11
	assign mis = raw & ~msk_q; // R12

	// ============================================================
	// gpio interrupt detection and output buffers
	logic wake_q, gpio_irq_q, host_irq_n_q;
	dkg_gpio_t out_q, oe_q;
	genvar g;
	generate
		for (g = 0; g < 24; g++) begin : g_gpio
			logic watch, cond;
			assign watch = !dir_q[g] && !ksel_q[g]; // R16
			assign cond = is_q[g] ? clean[g] == iev_q[g]
				: (ibe_q[g] ? clean[g] != gprev_q[g]
				: clean[g] != gprev_q[g] && clean[g] == iev_q[g]);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					gprev_q[g] <= 1'b1;
					gris_q[g] <= 1'b0;
					out_q[g] <= 1'b0;
					oe_q[g] <= 1'b0;
				end else begin
					gprev_q[g] <= clean[g];
					if (srst_q) gris_q[g] <= 1'b0; // R17
					else gris_q[g] <= (watch && cond) // R16
						|| (gris_q[g] && !(wr(`DKG_IX_GIC) && pwdata[g])); // R17
					out_q[g] <= ode_q[g] ? odm_q[g] : data_q[g]; // R19 R23
					oe_q[g] <= !srst_q && dir_q[g] && !ksel_q[g] // R1 R20
						&& (!ode_q[g] || data_q[g] == odm_q[g]); // R23
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_q <= 1'b0;
			gpio_irq_q <= 1'b0;
			host_irq_n_q <= 1'b1;
		end else begin
			wake_q <= (gris_q & ie_q) != '0; // R22
			gpio_irq_q <= (gris_q & ie_q) != '0; // R22
			host_irq_n_q <= !(irqen_q && mis != 2'h0); // R13
		end
	end

	assign pin_out = out_q;
	assign pin_oe = oe_q;
	assign pull_up = pu_q;
	assign pull_dn = pd_q;
	assign wake = wake_q;
	assign gpio_irq = gpio_irq_q;
	assign host_irq_n = host_irq_n_q;

	// ============================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_read_empty;
		psel && penable && !pready_q && !pwrite && idx == `DKG_IX_EVT && cnt_q == 4'h0;
	endsequence
	sequence s_overflow;
		ev_valid && full && !flush;
	endsequence

	a_empty_code: assert property (s_read_empty |=> // R4
		prdata_q == 32'h3f || prdata_q == 32'h1f)
		else $error("empty event read gave wrong code");
	a_fifo_bound: assert property (cnt_q <= 4'h8) // R3
		else $error("event fifo count above eight");
	a_overflow_keeps: assert property (s_overflow and !pop |=> lost_q && cnt_q == 4'h8) // R25
		else $error("overflow did not keep fifo and set lost");
	a_lost_sticky: assert property (lost_q && !flush |=> lost_q) // R10
		else $error("lost flag dropped without clear");
	a_clear_flush: assert property (flush && !ev_valid |=> cnt_q == 4'h0 && !raw[0]) // R14
		else $error("clear did not flush fifo");
	a_irq_pin_low: assert property (irqen_q && mis != 2'h0 |=> !host_irq_n_q) // R13
		else $error("host irq not asserted");
	a_mask_gate: assert property (msk_q[1] |-> !mis[1]) // R12
		else $error("masked lost bit visible");
	a_key_no_drive: assert property (##1 (oe_q & $past(ksel_q[23:0])) == '0) // R1
		else $error("key pin driven as output");
	a_soft_reset: assert property (srst_q |=> oe_q == '0 ##0 pu_q == '0) // R20 R21
		else $error("soft reset left outputs or pulls");
	a_gpio_wake: assert property ((gris_q & ie_q) != '0 |=> wake_q && gpio_irq_q) // R22
		else $error("wake not raised");
endmodule
`default_nettype wire

// >>> hdl/dkg_cfg.svh
/*
 * dkg_cfg.svh: register indices, field positions, reset values and
 * timing counts of the direct-key gpio input unit.
 * assumes: apb byte address = 4 * register index, word aligned.
 */
`ifndef DKG_CFG_SVH
`define DKG_CFG_SVH

// ============================================================
// register indices (byte address = index * 4)
`define DKG_IX_EVT 10'h0e6
`define DKG_IX_DB 10'h0e8
`define DKG_IX_SEL0 10'h0ec
`define DKG_IX_SEL1 10'h0ed
`define DKG_IX_SEL2 10'h0ee
`define DKG_IX_SEL3 10'h0ef
`define DKG_IX_RIS 10'h0f0
`define DKG_IX_MIS 10'h0f1
`define DKG_IX_CLR 10'h0f2
`define DKG_IX_MSK 10'h0f3
`define DKG_IX_DIR 10'h010
`define DKG_IX_DATA 10'h011
`define DKG_IX_ODE 10'h012
`define DKG_IX_ODM 10'h013
`define DKG_IX_PU 10'h014
`define DKG_IX_PD 10'h015
`define DKG_IX_IS 10'h016
`define DKG_IX_IBE 10'h017
`define DKG_IX_IEV 10'h018
`define DKG_IX_IE 10'h019
`define DKG_IX_GRIS 10'h01a
`define DKG_IX_GIC 10'h01b
`define DKG_IX_CTRL 10'h01c
`define DKG_IX_PIN 10'h01d

// ============================================================
// fields and reset values
`define DKG_DB_SYNC_BIT 5
`define DKG_DB_RESET 6'h06
`define DKG_CLR_EVT_BIT 0
`define DKG_MSK_LOST_BIT 1
`define DKG_MSK_EVT_BIT 0
`define DKG_CTRL_IRQEN_BIT 0
`define DKG_CTRL_SRST_BIT 1
`define DKG_SEL_RESET 26'h3ffffff
`define DKG_CODE_IDLE 8'h3f
`define DKG_CODE_HELD 8'h1f
`define DKG_FIFO_DEPTH 4'h8

// ============================================================
// timing: de-bounce step is 128 core clock periods
`define DKG_DB_STEP 8'h80
`define DKG_DB_DIV_LAST 7'((`DKG_DB_STEP) - 8'h01)

`endif

// >>> hdl/dkg_pkg.sv
/*
 * dkg_pkg.sv: types of the direct-key gpio input unit.
 * assumes: dkg_cfg.svh is on the include path.
 */
package dkg_pkg;
	// ============================================================
	// types
	typedef logic [25:0] dkg_keys_t;
	typedef logic [23:0] dkg_gpio_t;
	typedef logic [7:0] dkg_byte_t;
	typedef logic [4:0] dkg_dbcnt_t;
endpackage

// >>> hdl/dkg_debounce.sv
/*
 * dkg_debounce.sv: per-pin de-bounce filter for all 26 lines.
 * assumes: raw inputs already synchronised to pclk; step is a
 * one-cycle enable every 128 clocks.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dkg_cfg.svh"

module dkg_debounce (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic srst,
	input wire logic step,
	input wire dkg_pkg::dkg_dbcnt_t count,
	input wire dkg_pkg::dkg_keys_t raw,
	output dkg_pkg::dkg_keys_t clean
);
	import dkg_pkg::*;

	// ============================================================
	// one counter per line
	genvar g;
	generate
		for (g = 0; g < 26; g++) begin : g_pin
			logic [4:0] cnt_q;
			logic st_q;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_q <= 5'h00;
					st_q <= 1'b1;
				end else if (srst) begin
					cnt_q <= 5'h00;
					st_q <= 1'b1;
				end else if (raw[g] == st_q) begin
					cnt_q <= 5'h00;
				end else if (count == 5'h00) begin
					st_q <= raw[g];
				end else if (step) begin
					// change accepted after count steps of 128 clocks
					if (5'(cnt_q + 5'h01) >= count) begin // R8
						st_q <= raw[g];
						cnt_q <= 5'h00;
					end else begin
						cnt_q <= 5'(cnt_q + 5'h01);
					end
				end
			end
			assign clean[g] = st_q;
		end
	endgenerate

	// ============================================================
	// checks
	a_db_no_glitch: assert property (@(posedge pclk) disable iff (!presetn)
		(count != 5'h00 && !srst && !step && raw == clean) |=> $stable(clean)) // R8
		else $error("de-bounced line moved without a step");
endmodule
`default_nettype wire

// >>> tb/dkg_keys.sv
/*
 * dkg_keys.sv: push-button and line model on the pin side.
 * assumes: a pressed key pulls its line low; idle lines sit high;
 * a gpio pin driven by the unit shows the unit's value.
 */
`timescale 1ns/1ps
`default_nettype none

module dkg_keys (
	input wire logic pclk,
	input wire dkg_pkg::dkg_gpio_t pin_out,
	input wire dkg_pkg::dkg_gpio_t pin_oe,
	output dkg_pkg::dkg_keys_t pin_in
);
	import dkg_pkg::*;
	dkg_keys_t down_q = '0;
	// ============================================================
	// line levels
	always_comb begin
		pin_in = ~down_q;
		for (int i = 0; i < 24; i++) begin
			if (pin_oe[i]) begin
				pin_in[i] = pin_out[i];
			end
		end
	end
	// ============================================================
	// key action, held for many cycles
	task automatic set_key(input int k, input logic dn);
		@(posedge pclk);
		down_q[k] <= dn;
	endtask
endmodule
`default_nettype wire

// >>> tb/direct_key_gpio_input_tb.sv
/*
 * direct_key_gpio_input_tb.sv: register-level bench for dkg_top.
 * assumes: dkg_cfg.svh on the include path; byte address = index*4.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dkg_cfg.svh"

module direct_key_gpio_input_tb;
	import dkg_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	dkg_keys_t pin_in;
	dkg_gpio_t pin_out;
	dkg_gpio_t pin_oe;
	dkg_gpio_t pull_up;
	dkg_gpio_t pull_dn;
	logic host_irq_n;
	logic gpio_irq;
	logic wake;
	logic [31:0] rd_d;
	logic er_d;
	int n_fail = 0;
	int compares = 0;

	always #2 pclk = ~pclk;

	dkg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pull_up(pull_up), .pull_dn(pull_dn),
		.host_irq_n(host_irq_n), .gpio_irq(gpio_irq), .wake(wake));
	dkg_keys keys (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

	// ============================================================
	// tasks
	task automatic end_sim;
		if (n_fail == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic wr, input logic [9:0] ix, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {ix, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk("pready", 1, pready);
		end
		rd_d = prdata;
		er_d = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	task automatic wr(input logic [9:0] ix, input logic [31:0] d);
		apb(1'b1, ix, d);
	endtask
	task automatic rc(input string nm, input logic [9:0] ix, input logic [31:0] e);
		apb(1'b0, ix, 32'h0);
		chk(nm, e, rd_d);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// ============================================================
	// watchdog
	initial begin
		wt(40000);
		n_fail++;
		end_sim();
	end

	// ============================================================
	// tests
	initial begin
		wt(3);
		presetn <= 1'b1;
		rc("sel0", `DKG_IX_SEL0, 32'hff);
		rc("sel1", `DKG_IX_SEL1, 32'hff);
		rc("sel2", `DKG_IX_SEL2, 32'hff);
		rc("sel3", `DKG_IX_SEL3, 32'h03);
		rc("db", `DKG_IX_DB, 32'h06);
		rc("msk", `DKG_IX_MSK, 32'h0);
		rc("ris", `DKG_IX_RIS, 32'h0);
		rc("evt", `DKG_IX_EVT, 32'h3f);
		chk("oe", 0, pin_oe);
		apb(1'b0, 10'h3ff, 32'h0);
		chk("err", 1, er_d);
		wr(`DKG_IX_DB, 32'h01);
		wr(`DKG_IX_CTRL, 32'h01);
		keys.set_key(3, 1);
		wt(400);
		rc("ris", `DKG_IX_RIS, 32'h1);
		chk("host_irq_n", 0, host_irq_n);
		keys.set_key(25, 1);
		wt(400);
		keys.set_key(3, 0);
		wt(400);
		rc("evt", `DKG_IX_EVT, 32'h04);
		rc("evt", `DKG_IX_EVT, 32'h1a);
		rc("evt", `DKG_IX_EVT, 32'h24);
		rc("evt", `DKG_IX_EVT, 32'h1f);
		rc("ris", `DKG_IX_RIS, 32'h0);
		chk("host_irq_n", 1, host_irq_n);
		keys.set_key(25, 0);
		wt(400);
		rc("evt", `DKG_IX_EVT, 32'h3a);
		rc("evt", `DKG_IX_EVT, 32'h3f);
		keys.set_key(3, 1);
		wt(400);
		rc("mis", `DKG_IX_MIS, 32'h1);
		wr(`DKG_IX_MSK, 32'h01);
		rc("mis", `DKG_IX_MIS, 32'h0);
		chk("host_irq_n", 1, host_irq_n);
		rc("ris", `DKG_IX_RIS, 32'h1);
		wr(`DKG_IX_MSK, 32'h0);
		wr(`DKG_IX_CLR, 32'h0);
		rc("ris", `DKG_IX_RIS, 32'h1);
		wr(`DKG_IX_CLR, 32'h1);
		rc("ris", `DKG_IX_RIS, 32'h0);
		rc("evt", `DKG_IX_EVT, 32'h1f);
		for (int i = 0; i < 10; i++) begin
			keys.set_key(0, ~i[0]);
			wt(400);
		end
		rc("ris", `DKG_IX_RIS, 32'h3);
		rc("mis", `DKG_IX_MIS, 32'h3);
		rc("evt", `DKG_IX_EVT, 32'h01);
		rc("evt", `DKG_IX_EVT, 32'h21);
		rc("ris", `DKG_IX_RIS, 32'h3);
		wr(`DKG_IX_CLR, 32'h1);
		rc("ris", `DKG_IX_RIS, 32'h0);
		wr(`DKG_IX_DB, 32'h04);
		keys.set_key(5, 1);
		wt(100);
		keys.set_key(5, 0);
		wt(800);
		rc("ris", `DKG_IX_RIS, 32'h0);
		keys.set_key(5, 1);
		wt(300);
		rc("ris", `DKG_IX_RIS, 32'h0);
		wt(400);
		rc("ris", `DKG_IX_RIS, 32'h1);
		keys.set_key(5, 0);
		keys.set_key(3, 0);
		wr(`DKG_IX_DIR, 32'h01);
		wr(`DKG_IX_DATA, 32'h01);
		chk("oe", 0, pin_oe);
		wr(`DKG_IX_SEL0, 32'hfc);
		chk("oe", 1, pin_oe);
		wr(`DKG_IX_ODE, 32'h01);
		wr(`DKG_IX_ODM, 32'h01);
		chk("out", 1, pin_out[0] & pin_oe[0]);
		wr(`DKG_IX_DATA, 32'h0);
		chk("oe", 0, pin_oe);
		wr(`DKG_IX_ODM, 32'h0);
		chk("oe", 1, pin_oe);
		chk("out", 0, pin_out[0]);
		wr(`DKG_IX_PU, 32'h02);
		wr(`DKG_IX_PD, 32'h04);
		chk("pu", 32'h02, pull_up);
		chk("pd", 32'h04, pull_dn);
		wr(`DKG_IX_GIC, 32'hff);
		wr(`DKG_IX_IE, 32'h03);
		keys.set_key(1, 1);
		wt(10);
		chk("girq", 1, gpio_irq);
		chk("wake", 1, wake);
		wr(`DKG_IX_GIC, 32'h02);
		chk("girq", 0, gpio_irq);
		wr(`DKG_IX_IS, 32'h02);
		rc("gris", `DKG_IX_GRIS, 32'h02);
		chk("girq", 1, gpio_irq);
		wr(`DKG_IX_IS, 32'h0);
		wr(`DKG_IX_GIC, 32'h02);
		chk("girq", 0, gpio_irq);
		wr(`DKG_IX_ODE, 32'h0);
		wr(`DKG_IX_DATA, 32'h01);
		wr(`DKG_IX_DATA, 32'h0);
		chk("girq", 0, gpio_irq);
		wr(`DKG_IX_IBE, 32'h02);
		keys.set_key(1, 0);
		wt(10);
		chk("girq", 1, gpio_irq);
		wr(`DKG_IX_CTRL, 32'h02);
		rc("sel0", `DKG_IX_SEL0, 32'hff);
		chk("pu", 0, pull_up);
		chk("oe", 0, pin_oe);
		chk("pd", 0, pull_dn);
		chk("girq", 0, gpio_irq);
		end_sim();
	end
endmodule
`default_nettype wire
